// ===== pkg/dpc_pkg.sv
`default_nettype none
package dpc_pkg;

    localparam int DPC_ADDR_W = 8;
    localparam int DPC_DATA_W = 32;

    // Register byte offsets.
    localparam logic [DPC_ADDR_W-1:0] DPC_OFF_CTRL = 8'h00;
    localparam logic [DPC_ADDR_W-1:0] DPC_OFF_OUT = 8'h04;
    localparam logic [DPC_ADDR_W-1:0] DPC_OFF_STAT = 8'h08;

    // Control register fields.
    localparam int DPC_CFG_LSB = 0;
    localparam int DPC_CFG_W = 6;
    localparam int DPC_INV_BIT = 6;
    localparam int DPC_LATCH_BIT = 7;
    localparam int DPC_CEN_BIT = 8;
    localparam int DPC_CTRL_W = 9;
    localparam int DPC_OUT_W = 2;
    localparam logic [DPC_CTRL_W-1:0] DPC_CTRL_RST = 9'h100;
    localparam logic [DPC_OUT_W-1:0] DPC_OUT_RST = 2'h0;

    // Shadow word carried to the link domain: {out data, control}.
    localparam int DPC_SHADOW_W = DPC_CTRL_W + DPC_OUT_W;
    localparam logic [DPC_SHADOW_W-1:0] DPC_SHADOW_RST = {DPC_OUT_RST, DPC_CTRL_RST};

    // Output field of the configuration word (bits 5:2).
    localparam logic [3:0] DPC_OUT_NONE = 4'h0;
    localparam logic [3:0] DPC_OUT_DDR = 4'h4;

    // Banks.
    localparam int DPC_RX_BANK = 3;
    localparam int DPC_TX_BANK_MAX = 3;

    localparam logic [1:0] DPC_RESP_OKAY = 2'h0;
    localparam logic [1:0] DPC_RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        DPC_IN_REG = 2'h0,
        DPC_IN_DIRECT = 2'h1,
        DPC_IN_REG_LATCH = 2'h2,
        DPC_IN_LATCH = 2'h3
    } dpc_in_mode_t;

    typedef enum logic [1:0] {
        DPC_REG_CTRL = 2'h0,
        DPC_REG_OUT = 2'h1,
        DPC_REG_STAT = 2'h2,
        DPC_REG_NONE = 2'h3
    } dpc_reg_t;

    function automatic dpc_reg_t dpc_decode(input logic [DPC_ADDR_W-1:0] addr);
        case (addr)
            DPC_OFF_CTRL: dpc_decode = DPC_REG_CTRL;
            DPC_OFF_OUT: dpc_decode = DPC_REG_OUT;
            DPC_OFF_STAT: dpc_decode = DPC_REG_STAT;
            default: dpc_decode = DPC_REG_NONE;
        endcase
    endfunction

endpackage
`default_nettype wire

// ===== pkg/dpc_regbus_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dpc_regbus_if;
    import dpc_pkg::*;
    logic wr_fire;
    logic [DPC_ADDR_W-1:0] wr_addr;
    logic [DPC_DATA_W-1:0] wr_data;
    logic [3:0] wr_strb;
    logic [DPC_ADDR_W-1:0] rd_addr;
    logic [DPC_DATA_W-1:0] rd_data;
    modport slave (output wr_fire, wr_addr, wr_data, wr_strb, rd_addr, input rd_data);
    modport regs (input wr_fire, wr_addr, wr_data, wr_strb, rd_addr, output rd_data);
endinterface
`default_nettype wire

// ===== rtl/dpc_axil_slave.sv
`timescale 1ns/1ns
`default_nettype none
module dpc_axil_slave
    import dpc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [DPC_ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [DPC_DATA_W-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [DPC_ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [DPC_DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp,
    dpc_regbus_if.slave rb
);

    logic aw_got_q;
    logic w_got_q;
    logic [DPC_ADDR_W-1:0] awaddr_q;
    logic [DPC_DATA_W-1:0] wdata_q;
    logic [3:0] wstrb_q;

    assign rb.wr_fire = aw_got_q & w_got_q;
    assign rb.wr_addr = awaddr_q;
    assign rb.wr_data = wdata_q;
    assign rb.wr_strb = wstrb_q;
    assign rb.rd_addr = i_araddr;

    ////////////////////////////////////////////////////////////////////////////
    // Write channels: address and data are taken in either order, one write at a time.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb_q <= '0;
            o_bvalid <= 1'b0;
            o_bresp <= DPC_RESP_OKAY;
        end else begin
            if (i_awvalid && o_awready) begin
                aw_got_q <= 1'b1;
                awaddr_q <= i_awaddr;
                o_awready <= 1'b0;
            end
            if (i_wvalid && o_wready) begin
                w_got_q <= 1'b1;
                wdata_q <= i_wdata;
                wstrb_q <= i_wstrb;
                o_wready <= 1'b0;
            end
            if (aw_got_q && w_got_q) begin
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
                o_bvalid <= 1'b1;
                o_bresp <= (dpc_decode(awaddr_q) == DPC_REG_NONE) ? DPC_RESP_SLVERR
                                                                  : DPC_RESP_OKAY;
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channel: data is captured at the address handshake.
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= '0;
            o_rresp <= DPC_RESP_OKAY;
        end else begin
            if (i_arvalid && o_arready) begin
                o_arready <= 1'b0;
                o_rvalid <= 1'b1;
                o_rdata <= rb.rd_data;
                o_rresp <= (dpc_decode(i_araddr) == DPC_REG_NONE) ? DPC_RESP_SLVERR
                                                                 : DPC_RESP_OKAY;
            end
            if (o_rvalid && i_rready) begin
                o_rvalid <= 1'b0;
                o_arready <= 1'b1;
            end
        end
    end

    a_read_answer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (i_arvalid && o_arready) |=> (o_rvalid && !o_arready))
        else $error("read answer not given one cycle after address");

    a_write_answer: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (aw_got_q && w_got_q) |=> o_bvalid)
        else $error("write response missing after both channels taken");

endmodule
`default_nettype wire

// ===== rtl/dpc_top.sv
// The implementer's own choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// [RULE_01] Input code 01 passes pad straight through.
// [RULE_02] Code 00 registers pad; enable low holds.
// [RULE_03] Code 11 latch: control 1 freezes, 0 flows.
// [RULE_04] Code 10 latches the registered value.
// [RULE_05] Clock invert setting swaps storage clock edges.
// [RULE_06] DDR-only input uses configuration word 000000.
// [RULE_07] Complement cell drives inverse of true data.
// [RULE_08] DDR output cells use configuration word 010000.
// [RULE_09] Differential receive only on bank three.
// [RULE_10] Differential output allowed on banks zero-three.
// [RULE_11] Clock pin feeds global buffer seven directly.
// [RULE_12] DDR out: first bit rising, second falling.
// [RULE_13] DDR in: first rising sample, second falling.
module dpc_top
    import dpc_pkg::*;
#(
    parameter int P_RX_BANK = 3,
    parameter int P_TX_BANK = 0
) (
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    input wire logic i_global_buffer_seven_clk,
    input wire logic i_pad_rx,
    output logic o_pad_p,
    output logic o_pad_n,
    output logic o_pad_oe,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [DPC_ADDR_W-1:0] i_awaddr,
    input wire logic i_wvalid,
    output logic o_wready,
    input wire logic [DPC_DATA_W-1:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    output logic o_bvalid,
    input wire logic i_bready,
    output logic [1:0] o_bresp,
    input wire logic i_arvalid,
    output logic o_arready,
    input wire logic [DPC_ADDR_W-1:0] i_araddr,
    output logic o_rvalid,
    input wire logic i_rready,
    output logic [DPC_DATA_W-1:0] o_rdata,
    output logic [1:0] o_rresp
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release and bus slave.
    logic [1:0] rst_sync_q;
    logic rst_n;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    dpc_regbus_if rb ();

    dpc_axil_slave u_slave (
        .i_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .i_awvalid(i_awvalid),
        .o_awready(o_awready),
        .i_awaddr(i_awaddr),
        .i_wvalid(i_wvalid),
        .o_wready(o_wready),
        .i_wdata(i_wdata),
        .i_wstrb(i_wstrb),
        .o_bvalid(o_bvalid),
        .i_bready(i_bready),
        .o_bresp(o_bresp),
        .i_arvalid(i_arvalid),
        .o_arready(o_arready),
        .i_araddr(i_araddr),
        .o_rvalid(o_rvalid),
        .i_rready(i_rready),
        .o_rdata(o_rdata),
        .o_rresp(o_rresp),
        .rb(rb.slave)
    );

    function automatic logic [DPC_DATA_W-1:0] dpc_merge(
        input logic [DPC_DATA_W-1:0] old_v,
        input logic [DPC_DATA_W-1:0] new_v,
        input logic [3:0] strb
    );
        logic [DPC_DATA_W-1:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[8*b +: 8] = new_v[8*b +: 8];
            end
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Register file; each write of control or output data toggles the request.
    logic [DPC_CTRL_W-1:0] ctrl_q;
    logic [DPC_OUT_W-1:0] out_q;
    logic req_tgl_q;
    logic [DPC_SHADOW_W-1:0] word_q;
    dpc_reg_t wr_reg;
    logic [DPC_DATA_W-1:0] wr_merged_ctrl;
    logic [DPC_DATA_W-1:0] wr_merged_out;

    assign wr_reg = dpc_decode(rb.wr_addr);
    assign wr_merged_ctrl = dpc_merge({23'h0, ctrl_q}, rb.wr_data, rb.wr_strb);
    assign wr_merged_out = dpc_merge({30'h0, out_q}, rb.wr_data, rb.wr_strb);

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= DPC_CTRL_RST;
            out_q <= DPC_OUT_RST;
            req_tgl_q <= 1'b0;
            word_q <= DPC_SHADOW_RST;
        end else if (rb.wr_fire) begin
            if (wr_reg == DPC_REG_CTRL) begin
                ctrl_q <= wr_merged_ctrl[DPC_CTRL_W-1:0];
                word_q <= {out_q, wr_merged_ctrl[DPC_CTRL_W-1:0]};
                req_tgl_q <= ~req_tgl_q;
            end else if (wr_reg == DPC_REG_OUT) begin
                out_q <= wr_merged_out[DPC_OUT_W-1:0];
                word_q <= {wr_merged_out[DPC_OUT_W-1:0], ctrl_q};
                req_tgl_q <= ~req_tgl_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input data returning from the link domain, two flip-flops per bit.
    logic [1:0] din_s1_q;
    logic [1:0] din_s2_q;
    logic [1:0] lk_din;

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            din_s1_q <= 2'h0;
            din_s2_q <= 2'h0;
        end else begin
            din_s1_q <= lk_din;
            din_s2_q <= din_s1_q;
        end
    end

    always_comb begin
        case (dpc_decode(rb.rd_addr))
            DPC_REG_CTRL: rb.rd_data = {23'h0, ctrl_q};
            DPC_REG_OUT: rb.rd_data = {30'h0, out_q};
            DPC_REG_STAT: rb.rd_data = {30'h0, din_s2_q};
            default: rb.rd_data = '0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link domain, clocked by the global buffer seven net straight from its pin.
    logic [1:0] lrst_q;
    logic lrst_n;
    logic [2:0] tgl_q;
    logic [DPC_SHADOW_W-1:0] shadow_q;
    dpc_in_mode_t mode;
    logic [3:0] out_field;
    logic inv;
    logic latch;
    logic cen;
    logic pad;
    logic rise_cap_q;
    logic fall_cap_q;
    logic rise_v;
    logic fall_v;
    logic hold_q;
    logic lat_src;
    logic latched;
    logic out_pos_q;
    logic out_neg_q;
    logic ddr_on;
    logic oe_q;
    logic ddr_bit;

    localparam logic RX_EN = (P_RX_BANK == DPC_RX_BANK);
    localparam logic TX_EN = (P_TX_BANK >= 0) && (P_TX_BANK <= DPC_TX_BANK_MAX);

    always_ff @(posedge i_global_buffer_seven_clk or negedge rst_n) begin // RULE_11
        if (!rst_n) begin
            lrst_q <= 2'h0;
        end else begin
            lrst_q <= {lrst_q[0], 1'b1};
        end
    end
    assign lrst_n = lrst_q[1];

    // The word changes with the toggle and is stable for two to three link cycles before the toggle is seen here.
    always_ff @(posedge i_global_buffer_seven_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            tgl_q <= 3'h0;
            shadow_q <= DPC_SHADOW_RST;
        end else begin
            tgl_q <= {tgl_q[1:0], req_tgl_q};
            if (tgl_q[2] != tgl_q[1]) begin
                shadow_q <= word_q;
            end
        end
    end

    assign mode = dpc_in_mode_t'(shadow_q[DPC_CFG_LSB +: 2]);
    assign out_field = shadow_q[DPC_CFG_LSB+2 +: 4];
    assign inv = shadow_q[DPC_INV_BIT];
    assign latch = shadow_q[DPC_LATCH_BIT];
    assign cen = shadow_q[DPC_CEN_BIT];
    assign pad = RX_EN ? i_pad_rx : 1'b0; // RULE_09

    // Pad capture on both edges; the enable holds the stored values.
    always_ff @(posedge i_global_buffer_seven_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            rise_cap_q <= 1'b0;
        end else if (cen) begin
            rise_cap_q <= pad; // RULE_02
        end
    end

    always_ff @(negedge i_global_buffer_seven_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            fall_cap_q <= 1'b0;
        end else if (cen) begin
            fall_cap_q <= pad; // RULE_13
        end
    end

    assign rise_v = inv ? fall_cap_q : rise_cap_q; // RULE_05 RULE_13
    assign fall_v = inv ? rise_cap_q : fall_cap_q; // RULE_05 RULE_13

    // Low-power latch, modelled as a hold register plus a flow-through mux.
    assign lat_src = (mode == DPC_IN_REG_LATCH) ? rise_v : pad; // RULE_04
    assign latched = latch ? hold_q : lat_src; // RULE_03

    always_ff @(posedge i_global_buffer_seven_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            hold_q <= 1'b0;
        end else if (!latch) begin
            hold_q <= lat_src;
        end
    end

    always_comb begin
        case (mode)
            DPC_IN_DIRECT: lk_din[0] = pad; // RULE_01
            DPC_IN_REG: lk_din[0] = rise_v; // RULE_02
            DPC_IN_LATCH: lk_din[0] = latched; // RULE_03
            DPC_IN_REG_LATCH: lk_din[0] = latched; // RULE_04
            default: lk_din[0] = pad;
        endcase
        lk_din[1] = (mode == DPC_IN_REG) ? fall_v : 1'b0; // RULE_13
    end

    ////////////////////////////////////////////////////////////////////////////
    // DDR output: one register per edge, the level of the clock picks the bit.
    always_ff @(posedge i_global_buffer_seven_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            out_pos_q <= 1'b0;
            oe_q <= 1'b0;
        end else begin
            out_pos_q <= inv ? shadow_q[DPC_CTRL_W+1] : shadow_q[DPC_CTRL_W]; // RULE_12
            oe_q <= ddr_on;
        end
    end

    always_ff @(negedge i_global_buffer_seven_clk or negedge lrst_n) begin
        if (!lrst_n) begin
            out_neg_q <= 1'b0;
        end else begin
            out_neg_q <= inv ? shadow_q[DPC_CTRL_W] : shadow_q[DPC_CTRL_W+1]; // RULE_12
        end
    end

    assign ddr_on = TX_EN && (out_field == DPC_OUT_DDR); // RULE_10
    assign ddr_bit = i_global_buffer_seven_clk ? out_pos_q : out_neg_q; // RULE_12
    assign o_pad_p = oe_q & ddr_bit;
    assign o_pad_n = oe_q & ~ddr_bit; // RULE_07
    assign o_pad_oe = oe_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the link-domain cell.
    sequence s_latch_held;
        (mode == DPC_IN_LATCH && latch) [*2];
    endsequence

    sequence s_ddr_capture;
        (mode == DPC_IN_REG && cen && !inv);
    endsequence

    a_direct_pass: assert property (@(posedge i_global_buffer_seven_clk) // RULE_01
        disable iff (!lrst_n) (mode == DPC_IN_DIRECT) |-> (lk_din[0] == pad))
        else $error("direct mode does not pass the pad");

    a_capture_hold: assert property (@(posedge i_global_buffer_seven_clk) // RULE_02
        disable iff (!lrst_n) (!cen && !$past(cen)) |-> $stable(rise_cap_q))
        else $error("registered input changed while capture disabled");

    a_latch_freeze: assert property (@(posedge i_global_buffer_seven_clk) // RULE_03
        disable iff (!lrst_n) s_latch_held |-> $stable(lk_din[0]))
        else $error("latched input did not hold");

    a_latch_flow: assert property (@(posedge i_global_buffer_seven_clk) // RULE_03
        disable iff (!lrst_n) (mode == DPC_IN_LATCH && !latch) |-> (lk_din[0] == pad))
        else $error("open latch does not flow through");

    a_reg_latch: assert property (@(posedge i_global_buffer_seven_clk) // RULE_04
        disable iff (!lrst_n) (mode == DPC_IN_REG_LATCH && !latch) |-> (lk_din[0] == rise_v))
        else $error("registered latch mode does not show the register");

    a_ddr_rise_in: assert property (@(posedge i_global_buffer_seven_clk) // RULE_13
        disable iff (!lrst_n) s_ddr_capture |=> (mode != DPC_IN_REG || inv ||
        lk_din[0] == $past(pad)))
        else $error("first input output is not the rising sample");

    a_inv_swap: assert property (@(posedge i_global_buffer_seven_clk) // RULE_05
        disable iff (!lrst_n) (mode == DPC_IN_REG && cen && inv) ##1
        (mode == DPC_IN_REG && inv) |-> (lk_din[1] == $past(pad)))
        else $error("inverted clock did not move capture to the other edge");

    a_ddr_out_rise: assert property (@(posedge i_global_buffer_seven_clk) // RULE_12
        disable iff (!lrst_n) !inv |=> (out_pos_q == $past(shadow_q[DPC_CTRL_W])))
        else $error("first output bit not loaded at rising edge");

    a_rx_bank: assert property (@(posedge i_global_buffer_seven_clk) // RULE_09
        disable iff (!lrst_n) !RX_EN |-> (pad == 1'b0))
        else $error("receiver active outside its bank");

    a_pair_inverse: assert property (@(posedge i_global_buffer_seven_clk) // RULE_07
        disable iff (!lrst_n) oe_q |-> (o_pad_n == !o_pad_p))
        else $error("complement pad is not the inverse");

endmodule
`default_nettype wire

// ===== verif/dpc_lvds_peer.sv
`timescale 1ns/1ns
`default_nettype none
module dpc_lvds_peer (
    input wire logic i_rise_bit,
    input wire logic i_fall_bit,
    output logic o_lclk,
    output logic o_pad
);
    // Free-running link clock of 15 ns, offset from the system clock.
    initial begin
        o_lclk = 1'b0;
        o_pad = 1'b0;
        #3;
        forever begin
            o_lclk = 1'b1;
            #8;
            o_lclk = 1'b0;
            #7;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Data moves mid-phase so that each clock edge sees a settled bit.
    always @(posedge o_lclk) begin
        #4 o_pad = i_fall_bit;
    end
    always @(negedge o_lclk) begin
        #3 o_pad = i_rise_bit;
    end
endmodule
`default_nettype wire

// ===== verif/test_dpc_top.sv
`timescale 1ns/1ns
`default_nettype none
module test_dpc_top
    import dpc_pkg::*;
;
    logic clk, nrst, lclk, pad, rise_b, fall_b;
    logic awvalid, wvalid, bready, arvalid, rready;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [3:0] wstrb;
    logic awready, wready, bvalid, arready, rvalid, pad_p, pad_n, pad_oe;
    logic [1:0] bresp, rresp;
    int fail_count, compares;

    dpc_top uut (
        .i_ref_clk(clk), .i_nrst(nrst), .i_global_buffer_seven_clk(lclk),
        .i_pad_rx(pad), .o_pad_p(pad_p), .o_pad_n(pad_n), .o_pad_oe(pad_oe),
        .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
        .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
        .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
        .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
        .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp)
    );
    dpc_lvds_peer peer (
        .i_rise_bit(rise_b), .i_fall_bit(fall_b), .o_lclk(lclk), .o_pad(pad)
    );

    always #5 clk = ~clk;

    ////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chkb(input string nm, input logic e, input logic g);
        chk(nm, {31'h0, e}, {31'h0, g});
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                chk("bresp", {30'h0, er}, {30'h0, bresp});
                n = 100;
            end
        end
        if (n < 100) begin
            chkb("write_wait", 1'b1, 1'b0);
            tally_and_finish();
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (n < 50) begin
            @(posedge clk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                chk("rdata", e, rdata & m);
                chk("rresp", {30'h0, er}, {30'h0, rresp});
                n = 100;
            end
        end
        if (n < 100) begin
            chkb("read_wait", 1'b1, 1'b0);
            tally_and_finish();
        end
    endtask

    task automatic settle();
        repeat (16) @(posedge clk);
    endtask

    task automatic padchk(input logic [1:0] v);
        @(posedge lclk);
        #2;
        chkb("pad_p_first", v[0], pad_p);
        chkb("pad_n_first", ~v[0], pad_n);
        @(negedge lclk);
        #2;
        chkb("pad_p_second", v[1], pad_p);
        chkb("pad_n_second", ~v[1], pad_n);
    endtask

    // Sets the control word, then the pad pattern, then reads the captured bits.
    task automatic step(input logic [8:0] c, input logic r, input logic f,
                        input logic [1:0] e, input logic [1:0] m);
        wr(DPC_OFF_CTRL, {23'h0, c}, 4'hf, DPC_RESP_OKAY);
        settle();
        rise_b <= r;
        fall_b <= f;
        settle();
        rd(DPC_OFF_STAT, {30'h0, e}, {30'h0, m}, DPC_RESP_OKAY);
    endtask

    ////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        nrst = 1'b0;
        rise_b = 1'b0;
        fall_b = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        awaddr = 8'h0;
        araddr = 8'h0;
        wdata = 32'h0;
        wstrb = 4'hf;
        fail_count = 0;
        compares = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (3) @(posedge clk);
        rd(DPC_OFF_CTRL, 32'h100, 32'hffffffff, DPC_RESP_OKAY);
        rd(DPC_OFF_OUT, 32'h0, 32'hffffffff, DPC_RESP_OKAY);
        chkb("pad_oe_idle", 1'b0, pad_oe);
        rd(8'h0c, 32'h0, 32'hffffffff, DPC_RESP_SLVERR);
        wr(8'h0c, 32'h3, 4'hf, DPC_RESP_SLVERR);
        wr(DPC_OFF_STAT, 32'h3, 4'hf, DPC_RESP_OKAY);
        wr(DPC_OFF_CTRL, 32'h110, 4'hf, DPC_RESP_OKAY);
        for (int i = 1; i < 4; i++) begin
            wr(DPC_OFF_OUT, i, 4'hf, DPC_RESP_OKAY);
            settle();
            padchk(i[1:0]);
        end
        chkb("pad_oe", 1'b1, pad_oe);
        wr(DPC_OFF_OUT, 32'h0, 4'h0, DPC_RESP_OKAY);
        rd(DPC_OFF_OUT, 32'h3, 32'hffffffff, DPC_RESP_OKAY);
        wr(DPC_OFF_CTRL, 32'h150, 4'hf, DPC_RESP_OKAY);
        wr(DPC_OFF_OUT, 32'h1, 4'hf, DPC_RESP_OKAY);
        settle();
        padchk(2'h2);
        step(9'h101, 1'b0, 1'b0, 2'h0, 2'h1);
        step(9'h101, 1'b1, 1'b1, 2'h1, 2'h1);
        step(9'h100, 1'b1, 1'b0, 2'h1, 2'h3);
        step(9'h000, 1'b0, 1'b1, 2'h1, 2'h3);
        step(9'h140, 1'b0, 1'b1, 2'h1, 2'h3);
        step(9'h100, 1'b0, 1'b1, 2'h2, 2'h3);
        step(9'h103, 1'b1, 1'b1, 2'h1, 2'h1);
        step(9'h183, 1'b0, 1'b0, 2'h1, 2'h1);
        step(9'h103, 1'b0, 1'b0, 2'h0, 2'h1);
        step(9'h102, 1'b1, 1'b1, 2'h1, 2'h1);
        step(9'h002, 1'b0, 1'b0, 2'h1, 2'h1);
        step(9'h102, 1'b0, 1'b0, 2'h0, 2'h1);
        step(9'h182, 1'b1, 1'b1, 2'h0, 2'h1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
